// file: hw/ccs_top.sv
// snapshot, compare and preload logic for six counter channels
// What this block does
// - cause field: 8 qerr, 7 soft, 6/5 aux rise/fall, 4/3 index, 2 zero, 1/0 match
// - simultaneous triggers make one entry with all their cause bits
// - match-caused entry holds count equal to the firing match register
// - entry holds count, timestamp, cause; pushed into per-channel queue
// - reading an entry pops it; each delivered once
// - encoding error captures entry with bit 8 and sets error flag
// - while error flag set, further errors ignored, other triggers still capture
// - error flag clears on its entry popped, halt, or queue empty
// - capture into full queue dropped; overflow shown and cleared by next pop
// - entry-available status exposed; empty read reported not ready
// - soft capture command captures current count while running
// - two match registers per channel, index 0 and 1, read/write
// - instantaneous count read returns core count, no entry made
// - two 32-bit load-value registers per channel, index 2 and 3
// - load-value write takes effect at once; core waits for its load event
// - six independent channels, 0 through 5
// - triggered capture written to queue 40 ns after its edge
// - reset zeroes match and load-value registers of every channel
// - halted channel: queue empty, core held at zero
`timescale 1ns/1ns
`include "ccs_consts.svh"

////////////////////////////////////////////////////////////////////////
module ccs_chan #(
  parameter int QDEPTH = 4
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic        run,
  input  wire logic [31:0] core_count,
  input  wire logic [31:0] match_a,
  input  wire logic [31:0] match_b,
  input  wire logic [31:0] tstamp,
  input  wire logic        quad_err,
  input  wire logic        idx_rise,
  input  wire logic        idx_fall,
  input  wire logic        aux_rise,
  input  wire logic        aux_fall,
  input  wire logic        soft_cap,
  input  wire logic        pop,
  output logic [31:0]      head_count,
  output logic [31:0]      head_ts,
  output ccs_pkg::ccs_cause_t head_cause,
  output logic             avail,
  output logic             ovf,
  output logic             err_flag
);
  localparam int PW = `CCS_CAPT_CYC - 1;
  localparam int AW = (QDEPTH > 1) ? $clog2(QDEPTH) : 1;
  localparam logic [AW:0] FULLN = (AW + 1)'(QDEPTH);
  localparam logic [AW-1:0] LASTI = AW'(QDEPTH - 1);

  ccs_pkg::ccs_cause_t cause;
  ccs_pkg::ccs_cause_t pc_q [PW];
  logic [31:0]         pn_q [PW];
  logic [31:0]         pt_q [PW];
  logic [PW-1:0]       pv_q;
  logic [31:0]         prev_q;
  logic [31:0]         mc_q [QDEPTH];
  logic [31:0]         mt_q [QDEPTH];
  ccs_pkg::ccs_cause_t ms_q [QDEPTH];
  logic [AW-1:0]       wr_q;
  logic [AW-1:0]       rd_q;
  logic [AW:0]         cnt_q;
  logic                err_q;
  logic                ovf_q;
  logic                moved;
  logic                qerr_fly;
  logic                push;
  logic                full;
  logic                do_push;
  logic                do_pop;

  assign moved = core_count != prev_q;

  // errors still in the delay line count as flagged already
  always_comb begin
    qerr_fly = 1'b0;
    for (int i = 0; i < PW; i++) begin
      qerr_fly = qerr_fly | (pv_q[i] & pc_q[i][`CCS_C_QERR]);
    end
  end

  always_comb begin
    cause = '0;
    if (run) begin
      cause[`CCS_C_QERR] = quad_err & ~err_q & ~qerr_fly;
      cause[`CCS_C_SOFT] = soft_cap;
      cause[`CCS_C_AXR]  = aux_rise;
      cause[`CCS_C_AXF]  = aux_fall;
      cause[`CCS_C_IXR]  = idx_rise;
      cause[`CCS_C_IXF]  = idx_fall;
      cause[`CCS_C_ZERO] = moved & (core_count == 32'h00000000);
      cause[`CCS_C_MB]   = moved & (core_count == match_b);
      cause[`CCS_C_MA]   = moved & (core_count == match_a);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= 32'h00000000;
    end else if (clk_en) begin
      prev_q <= core_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // delay line: entry reaches the queue CAPT_CYC cycles after its trigger
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pv_q <= '0;
      for (int i = 0; i < PW; i++) begin
        pc_q[i] <= '0;
        pn_q[i] <= 32'h00000000;
        pt_q[i] <= 32'h00000000;
      end
    end else if (clk_en) begin
      if (!run) begin
        pv_q <= '0;
      end else begin
        pv_q[0] <= |cause;
        pc_q[0] <= cause;
        pn_q[0] <= core_count;
        pt_q[0] <= tstamp;
        for (int i = 1; i < PW; i++) begin
          pv_q[i] <= pv_q[i-1];
          pc_q[i] <= pc_q[i-1];
          pn_q[i] <= pn_q[i-1];
          pt_q[i] <= pt_q[i-1];
        end
      end
    end
  end

  assign push    = run & pv_q[PW-1];
  assign full    = cnt_q == FULLN;
  assign do_push = push & ~full;
  assign do_pop  = run & pop & (cnt_q != '0);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < QDEPTH; i++) begin
        mc_q[i] <= 32'h00000000;
        mt_q[i] <= 32'h00000000;
        ms_q[i] <= '0;
      end
    end else if (clk_en && do_push) begin
      mc_q[wr_q] <= pn_q[PW-1];
      mt_q[wr_q] <= pt_q[PW-1];
      ms_q[wr_q] <= pc_q[PW-1];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (clk_en) begin
      if (!run) begin
        wr_q  <= '0;
        rd_q  <= '0;
        cnt_q <= '0;
      end else begin
        if (do_push) begin
          wr_q <= (wr_q == LASTI) ? '0 : wr_q + 1'b1;
        end
        if (do_pop) begin
          rd_q <= (rd_q == LASTI) ? '0 : rd_q + 1'b1;
        end
        cnt_q <= cnt_q + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
      end
    end
  end

  // set wins over the pop and empty clears; halt clears over set
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      err_q <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        err_q <= 1'b0;
      end else if (push && pc_q[PW-1][`CCS_C_QERR]) begin
        err_q <= 1'b1;
      end else if ((do_pop && head_cause[`CCS_C_QERR]) || cnt_q == '0) begin
        err_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ovf_q <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        ovf_q <= 1'b0;
      end else if (push && full) begin
        ovf_q <= 1'b1;
      end else if (do_pop) begin
        ovf_q <= 1'b0;
      end
    end
  end

  assign head_count = mc_q[rd_q];
  assign head_ts    = mt_q[rd_q];
  assign head_cause = ms_q[rd_q];
  assign avail      = cnt_q != '0;
  assign ovf        = ovf_q;
  assign err_flag   = err_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn || !clk_en);

  sequence s_trig;
    run && (|cause) ##1 run [*3];
  endsequence
  sequence s_soft;
    run && soft_cap ##1 run [*3];
  endsequence
  sequence s_qerr_masked;
    run && err_q && quad_err ##1 run [*3];
  endsequence

  a_capt_delay: assert property (s_trig |-> push)
    else $error("capture did not reach queue in time");
  a_soft_entry: assert property (s_soft |-> push && pc_q[PW-1][`CCS_C_SOFT])
    else $error("soft capture lost");
  a_ovf_set: assert property (push && full |=> ovf_q)
    else $error("overflow not flagged");
  a_ovf_clear: assert property (do_pop && !(push && full) |=> !ovf_q)
    else $error("overflow not cleared by pop");
  a_err_mask: assert property (s_qerr_masked |-> !(push && pc_q[PW-1][`CCS_C_QERR]))
    else $error("error capture while flagged");
  a_err_set: assert property (push && pc_q[PW-1][`CCS_C_QERR] |=> err_q)
    else $error("error flag not set");
  a_err_empty: assert property (run && err_q && cnt_q == '0 && !push |=> !err_q)
    else $error("error flag survived empty queue");
  a_halt_empty: assert property (!run |=> cnt_q == '0 && !err_q && !ovf_q)
    else $error("halted channel not empty");
  a_pop_count: assert property (do_pop && !do_push |=> cnt_q == $past(cnt_q) - 1'b1)
    else $error("pop did not remove entry");
endmodule // ccs_chan

////////////////////////////////////////////////////////////////////////
module ccs_top #(
  parameter int QDEPTH = 4
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         clk_en,
  input  wire logic [7:0]   address,
  input  wire logic         read,
  input  wire logic         write,
  input  wire logic [31:0]  writedata,
  input  wire logic [3:0]   byteenable,
  output logic [31:0]       readdata,
  output logic              waitrequest,
  input  wire logic [191:0] core_count,
  input  wire logic [5:0]   quad_err,
  input  wire logic [5:0]   idx_rise,
  input  wire logic [5:0]   idx_fall,
  input  wire logic [5:0]   aux_rise,
  input  wire logic [5:0]   aux_fall,
  output logic [5:0]        chan_run,
  output logic [191:0]      load_value_a,
  output logic [191:0]      load_value_b
);
  localparam int NCH = `CCS_NCH;

  ccs_pkg::ccs_bus_t   bus_q;
  ccs_pkg::ccs_cause_t h_cs [NCH];
  logic [31:0]         h_cnt [NCH];
  logic [31:0]         h_ts [NCH];
  logic [31:0]         ma_q [NCH];
  logic [31:0]         mb_q [NCH];
  logic [31:0]         la_q [NCH];
  logic [31:0]         lb_q [NCH];
  logic [NCH-1:0]      run_q;
  logic [NCH-1:0]      soft_q;
  logic [NCH-1:0]      av;
  logic [NCH-1:0]      ov;
  logic [NCH-1:0]      er;
  logic [31:0]         ts_q;
  logic [31:0]         rdata_q;
  logic [31:0]         rmux;
  logic                pend_q;
  logic                acc;
  logic                hit;
  logic [2:0]          ch;
  logic [3:0]          rg;

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b*8 +: 8] = d[b*8 +: 8];
    end
    return r;
  endfunction

  assign ch  = address[6:4];
  assign rg  = address[3:0];
  assign hit = !address[7] && (ch < 3'h6);

  ////////////////////////////////////////////////////////////////////////
  // one wait state: read data is registered before the accepting edge
  assign waitrequest = (read | write) & ~(bus_q == ccs_pkg::CCS_BUS_ACK && clk_en);
  assign acc         = (read | write) & (bus_q == ccs_pkg::CCS_BUS_ACK) & clk_en;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bus_q <= ccs_pkg::CCS_BUS_IDLE;
    end else if (clk_en) begin
      unique case (bus_q)
        ccs_pkg::CCS_BUS_IDLE: begin
          if (read || write) bus_q <= ccs_pkg::CCS_BUS_ACK;
        end
        ccs_pkg::CCS_BUS_ACK: begin
          bus_q <= ccs_pkg::CCS_BUS_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    rmux = 32'h00000000;
    if (hit) begin
      unique case (rg)
        `CCS_R_MATCH_A:  rmux = ma_q[ch];
        `CCS_R_MATCH_B:  rmux = mb_q[ch];
        `CCS_R_LOAD_A:   rmux = la_q[ch];
        `CCS_R_LOAD_B:   rmux = lb_q[ch];
        `CCS_R_COUNT:    rmux = core_count[ch*32 +: 32];
        `CCS_R_CTRL:     rmux[`CCS_CTRL_RUN] = run_q[ch];
        `CCS_R_STATUS: begin
          rmux[`CCS_ST_AVAIL] = av[ch];
          rmux[`CCS_ST_OVF]   = ov[ch];
          rmux[`CCS_ST_ERR]   = er[ch];
        end
        `CCS_R_SNAP_CNT: rmux = h_cnt[ch];
        `CCS_R_SNAP_TS:  rmux = h_ts[ch];
        `CCS_R_SNAP_CS: begin
          rmux[8:0]          = av[ch] ? h_cs[ch] : 9'h000;
          rmux[`CCS_SC_OVF]  = av[ch] & ov[ch];
          rmux[`CCS_SC_NRDY] = ~av[ch];
        end
        default:         rmux = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h00000000;
      pend_q  <= 1'b0;
    end else if (clk_en && bus_q == ccs_pkg::CCS_BUS_IDLE && read) begin
      rdata_q <= rmux;
      pend_q  <= hit && rg == `CCS_R_SNAP_CS && av[ch];
    end
  end
  assign readdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      run_q  <= '0;
      soft_q <= '0;
      for (int c = 0; c < NCH; c++) begin
        ma_q[c] <= `CCS_RST_REG;
        mb_q[c] <= `CCS_RST_REG;
        la_q[c] <= `CCS_RST_REG;
        lb_q[c] <= `CCS_RST_REG;
      end
    end else if (clk_en) begin
      soft_q <= '0;
      if (acc && write && hit) begin
        unique case (rg)
          `CCS_R_MATCH_A: ma_q[ch] <= be_merge(ma_q[ch], writedata, byteenable);
          `CCS_R_MATCH_B: mb_q[ch] <= be_merge(mb_q[ch], writedata, byteenable);
          `CCS_R_LOAD_A:  la_q[ch] <= be_merge(la_q[ch], writedata, byteenable);
          `CCS_R_LOAD_B:  lb_q[ch] <= be_merge(lb_q[ch], writedata, byteenable);
          `CCS_R_CTRL: begin
            if (byteenable[0]) begin
              run_q[ch]  <= writedata[`CCS_CTRL_RUN];
              soft_q[ch] <= writedata[`CCS_CTRL_SOFT];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // free-running timestamp source
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ts_q <= 32'h00000000;
    end else if (clk_en) begin
      ts_q <= ts_q + 32'h00000001;
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    ccs_chan #(.QDEPTH(QDEPTH)) u_ch (
      .ref_clk    (ref_clk),
      .rstn       (rstn),
      .clk_en     (clk_en),
      .run        (run_q[c]),
      .core_count (core_count[c*32 +: 32]),
      .match_a    (ma_q[c]),
      .match_b    (mb_q[c]),
      .tstamp     (ts_q),
      .quad_err   (quad_err[c]),
      .idx_rise   (idx_rise[c]),
      .idx_fall   (idx_fall[c]),
      .aux_rise   (aux_rise[c]),
      .aux_fall   (aux_fall[c]),
      .soft_cap   (soft_q[c]),
      .pop        (acc && read && pend_q && hit && rg == `CCS_R_SNAP_CS && ch == 3'(c)),
      .head_count (h_cnt[c]),
      .head_ts    (h_ts[c]),
      .head_cause (h_cs[c]),
      .avail      (av[c]),
      .ovf        (ov[c]),
      .err_flag   (er[c])
    );
    assign load_value_a[c*32 +: 32] = la_q[c];
    assign load_value_b[c*32 +: 32] = lb_q[c];
  end
  assign chan_run = run_q;
endmodule // ccs_top

// file: hw/ccs_consts.svh
// register map, cause bit positions, reset values and timing counts
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH
`define CCS_NCH        6
`define CCS_R_MATCH_A  4'h0
`define CCS_R_MATCH_B  4'h1
`define CCS_R_LOAD_A   4'h2
`define CCS_R_LOAD_B   4'h3
`define CCS_R_COUNT    4'h4
`define CCS_R_CTRL     4'h5
`define CCS_R_STATUS   4'h6
`define CCS_R_SNAP_CNT 4'h7
`define CCS_R_SNAP_TS  4'h8
`define CCS_R_SNAP_CS  4'h9
`define CCS_CTRL_RUN   0
`define CCS_CTRL_SOFT  1
`define CCS_ST_AVAIL   0
`define CCS_ST_OVF     1
`define CCS_ST_ERR     2
`define CCS_SC_OVF     16
`define CCS_SC_NRDY    17
`define CCS_C_MA       0
`define CCS_C_MB       1
`define CCS_C_ZERO     2
`define CCS_C_IXF      3
`define CCS_C_IXR      4
`define CCS_C_AXF      5
`define CCS_C_AXR      6
`define CCS_C_SOFT     7
`define CCS_C_QERR     8
`define CCS_RST_REG    32'h00000000
`define CCS_CAPT_NS    40
`define CCS_CLK_NS     10
`define CCS_CAPT_CYC   ((`CCS_CAPT_NS + `CCS_CLK_NS - 1) / `CCS_CLK_NS)
`endif

// file: hw/ccs_pkg.sv
// shared types of the capture block
package ccs_pkg;
  typedef logic [8:0] ccs_cause_t;
  typedef enum logic [1:0] {
    CCS_BUS_IDLE = 2'h1,
    CCS_BUS_ACK  = 2'h2
  } ccs_bus_t;
endpackage

// file: test/ccs_top_tb.sv
// self-checking bench for the six-channel capture block
`timescale 1ns/1ns
`include "ccs_consts.svh"

module ccs_top_tb;
  logic         ref_clk;
  logic         rstn;
  logic         clk_en;
  logic [7:0]   address;
  logic         read;
  logic         write;
  logic [31:0]  writedata;
  logic [31:0]  readdata;
  logic         waitrequest;
  logic [191:0] core_count;
  logic [5:0]   quad_err;
  logic [5:0]   idx_rise;
  logic [5:0]   idx_fall;
  logic [5:0]   aux_rise;
  logic [5:0]   aux_fall;
  logic [5:0]   chan_run;
  logic [191:0] load_value_a;
  logic [191:0] load_value_b;
  int           errors   = 0;
  int           compares = 0;
  int           cycles   = 0;
  logic [31:0]  q;
  logic [31:0]  v;
  logic [31:0]  ma;
  logic [31:0]  mb;
  logic [31:0]  ts0;
  logic [31:0]  ts1;
  logic [2:0]   ch;

  ccs_top #(.QDEPTH(4)) dut (
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .clk_en       (clk_en),
    .address      (address),
    .read         (read),
    .write        (write),
    .writedata    (writedata),
    .byteenable   (4'hF),
    .readdata     (readdata),
    .waitrequest  (waitrequest),
    .core_count   (core_count),
    .quad_err     (quad_err),
    .idx_rise     (idx_rise),
    .idx_fall     (idx_fall),
    .aux_rise     (aux_rise),
    .aux_fall     (aux_fall),
    .chan_run     (chan_run),
    .load_value_a (load_value_a),
    .load_value_b (load_value_b)
  );

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] adr(input logic [2:0] c, input logic [3:0] r);
    return {1'b0, c, r};
  endfunction

  // pop word: cause in the low bits, overflow and not-ready above
  function automatic logic [31:0] csw(input logic [8:0] cause, input logic ovf);
    return {14'h0000, 1'b0, ovf, 7'h00, cause};
  endfunction

  task automatic finish_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon access; waitrequest sampled at rising edges, request dropped at the accepting edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq);
    @(posedge ref_clk);
    read      <= !wr;
    write     <= wr;
    address   <= a;
    writedata <= d;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) @(posedge ref_clk);
    rq = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] c, input logic [3:0] r, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, adr(c, r), d, dummy);
  endtask

  task automatic rd(input logic [2:0] c, input logic [3:0] r, output logic [31:0] rq);
    bus(1'b0, adr(c, r), 32'h00000000, rq);
  endtask

  // kind: 0 qerr, 1 index rise, 2 index fall, 3 aux rise, 4 aux fall
  task automatic pulse(input logic [2:0] c, input logic [4:0] kind);
    @(posedge ref_clk);
    quad_err[c] <= kind[0];
    idx_rise[c] <= kind[1];
    idx_fall[c] <= kind[2];
    aux_rise[c] <= kind[3];
    aux_fall[c] <= kind[4];
    @(posedge ref_clk);
    {quad_err, idx_rise, idx_fall, aux_rise, aux_fall} <= '0;
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic set_count(input logic [2:0] c, input logic [31:0] d);
    @(posedge ref_clk);
    core_count[c*32 +: 32] <= d;
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic take(input logic [2:0] c, input logic [31:0] cnt, input logic [8:0] cause,
                      input logic ovf, output logic [31:0] ts);
    logic [31:0] r;
    rd(c, `CCS_R_SNAP_CNT, r);
    chk(r, cnt);
    rd(c, `CCS_R_SNAP_TS, ts);
    rd(c, `CCS_R_SNAP_CS, r);
    chk(r, csw(cause, ovf));
  endtask

  task automatic expect_empty(input logic [2:0] c);
    logic [31:0] r;
    rd(c, `CCS_R_SNAP_CS, r);
    chk(r & 32'h00020000, 32'h00020000);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ceiling well above the several hundred cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h00000000;
    core_count = '0;
    {quad_err, idx_rise, idx_fall, aux_rise, aux_fall} = '0;
    void'($urandom(12706));
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int c = 0; c < 6; c++) begin
      for (int r = 0; r < 4; r++) begin
        rd(3'(c), 4'(r), q);
        chk(q, `CCS_RST_REG);
      end
    end
    for (int c = 0; c < 6; c++) begin
      for (int r = 0; r < 4; r++) begin
        v = $urandom();
        wr(3'(c), 4'(r), v);
        @(negedge ref_clk);
        if (r == 2) chk(load_value_a[c*32 +: 32], v);
        if (r == 3) chk(load_value_b[c*32 +: 32], v);
        rd(3'(c), 4'(r), q);
        chk(q, v);
      end
      v = $urandom() | 32'h00000001;
      core_count[c*32 +: 32] <= v;
      rd(3'(c), `CCS_R_COUNT, q);
      chk(q, v);
      rd(3'(c), `CCS_R_STATUS, q);
      chk(q, 32'h00000000);
    end
    rd(3'h6, `CCS_R_MATCH_A, q);
    chk(q, 32'h00000000);
    rd(3'h2, 4'hA, q);
    chk(q, 32'h00000000);
    ch = 3'($urandom_range(5));
    wr(ch, `CCS_R_CTRL, 32'h00000001);
    @(negedge ref_clk);
    chk({31'h0, chan_run[ch]}, 32'h00000001);
    v = $urandom() | 32'h00000001;
    set_count(ch, v);
    wr(ch, `CCS_R_CTRL, 32'h00000003);
    repeat (6) @(posedge ref_clk);
    rd(ch, `CCS_R_CTRL, q);
    chk(q, 32'h00000001);
    take(ch, v, 9'h080, 1'b0, ts0);
    wr(ch, `CCS_R_CTRL, 32'h00000003);
    repeat (6) @(posedge ref_clk);
    take(ch, v, 9'h080, 1'b0, ts1);
    chk({31'h0, ts1 > ts0}, 32'h00000001);
    pulse(ch, 5'b11110);
    rd(3'((ch + 1) % 6), `CCS_R_STATUS, q);
    chk(q, 32'h00000000);
    take(ch, v, 9'h078, 1'b0, ts0);
    expect_empty(ch);
    pulse(ch, 5'b00010);
    take(ch, v, 9'h010, 1'b0, ts0);
    pulse(ch, 5'b00100);
    take(ch, v, 9'h008, 1'b0, ts0);
    pulse(ch, 5'b01000);
    take(ch, v, 9'h040, 1'b0, ts0);
    pulse(ch, 5'b10000);
    take(ch, v, 9'h020, 1'b0, ts0);
    ma = $urandom() | 32'h00000001;
    mb = ma ^ 32'h00010000;
    wr(ch, `CCS_R_MATCH_A, ma);
    wr(ch, `CCS_R_MATCH_B, mb);
    set_count(ch, ma);
    take(ch, ma, 9'h001, 1'b0, ts0);
    set_count(ch, mb);
    take(ch, mb, 9'h002, 1'b0, ts0);
    set_count(ch, 32'h00000000);
    take(ch, 32'h00000000, 9'h004, 1'b0, ts0);
    // error flag: second error swallowed, index still captured
    pulse(ch, 5'b00001);
    rd(ch, `CCS_R_STATUS, q);
    chk(q, 32'h00000005);
    pulse(ch, 5'b00001);
    pulse(ch, 5'b00010);
    take(ch, 32'h00000000, 9'h100, 1'b0, ts0);
    take(ch, 32'h00000000, 9'h010, 1'b0, ts0);
    rd(ch, `CCS_R_STATUS, q);
    chk(q, 32'h00000000);
    pulse(ch, 5'b00001);
    take(ch, 32'h00000000, 9'h100, 1'b0, ts0);
    for (int i = 0; i < 5; i++) pulse(ch, 5'b00010);
    rd(ch, `CCS_R_STATUS, q);
    chk(q, 32'h00000003);
    take(ch, 32'h00000000, 9'h010, 1'b1, ts0);
    for (int i = 0; i < 3; i++) take(ch, 32'h00000000, 9'h010, 1'b0, ts0);
    expect_empty(ch);
    // frozen clock enable: an event pulse must leave no entry behind
    @(posedge ref_clk);
    clk_en <= 1'b0;
    pulse(ch, 5'b00010);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    expect_empty(ch);
    pulse(ch, 5'b00001);
    pulse(ch, 5'b00010);
    wr(ch, `CCS_R_CTRL, 32'h00000000);
    @(negedge ref_clk);
    chk({31'h0, chan_run[ch]}, 32'h00000000);
    rd(ch, `CCS_R_STATUS, q);
    chk(q, 32'h00000000);
    pulse(ch, 5'b11111);
    wr(ch, `CCS_R_CTRL, 32'h00000002);
    repeat (6) @(posedge ref_clk);
    rd(ch, `CCS_R_STATUS, q);
    chk(q, 32'h00000000);
    finish_test();
  end
endmodule // ccs_top_tb
